// *** core/acs_cfg.svh ***
// Register map, field positions, reset values and timing counts for the converter sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_IDX_CTRL 8'h7A
`define ACS_IDX_MUX 8'h7C
`define ACS_IDX_CTRL_B 8'h7B
`define ACS_IDX_RES_LO 8'h78
`define ACS_IDX_RES_HI 8'h79
`define ACS_BIT_ENABLE 7
`define ACS_BIT_START 6
`define ACS_BIT_AUTO 5
`define ACS_BIT_FLAG 4
`define ACS_BIT_IRQ_EN 3
`define ACS_BIT_LEFT_ADJ 5
`define ACS_MUX_WMASK 8'hEF
`define ACS_CTRL_RESET 8'h00
`define ACS_MUX_RESET 8'h00
`define ACS_CYC_FIRST 5'h19
`define ACS_CYC_NORMAL 5'h0D
`define ACS_CHAN_TEMP 4'h8
`define ACS_REF_INTERNAL 2'h3
`endif

// *** core/acs_pkg.sv ***
// Types for the converter sequencer
package acs_pkg;
  typedef enum logic [1:0] {ACS_IDLE, ACS_RUN, ACS_WAIT} acs_state_type;
endpackage

// *** core/acs_prescaler.sv ***
// Prescaler making the converter clock enable pulse from the system clock
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [2:0] i_div_sel,
  output logic o_tick
);
  logic [6:0] count;
  logic [6:0] limit;

  // Codes 0 and 1 both divide by two
  always_comb
  begin
    limit = (i_div_sel == 3'h0) ? 7'h01 : 7'((8'h01 << i_div_sel) - 8'h01);
  end

  // Counter held at zero while converter is off, saving power
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      count <= 7'h00;
    else if (!i_run || count >= limit)
      count <= 7'h00;
    else
      count <= count + 7'h01;
  end

  assign o_tick = i_run && (count >= limit);
endmodule
`default_nettype wire

// *** core/acs_sequencer.sv ***
// Converter control sequencer with APB register slave
//
// Behaviour
// - Channel 1000 routes and enables temperature sensor
// - Reference field selects external, supply, internal
// - Selection changes apply after current conversion
// - Left adjust bit changes readout immediately
// - Selection bit 4 reads zero always
// - Channel field picks inputs, bandgap, ground
// - Enable powers converter; clearing aborts conversion
// - Start bit begins conversion; free-run restarts
// - First conversion 25 ticks, others 13
// - Start reads one while busy; zero ignored
// - Auto trigger starts on trigger rising edge
// - Done flag sets with result update
// - Interrupt when flag, enable, global all set
// - Flag clears on vector or write one
// - Prescaler divides by 2 up to 128
// - Low byte read freezes result until high
// - Switching to free-run makes no trigger
// - Result placement right or left adjusted
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"
module acs_sequencer
  import acs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] i_trigger_sources,
  input wire logic i_global_irq_en,
  input wire logic i_irq_vector_ack,
  input wire logic i_core_done,
  input wire logic [9:0] i_core_result,
  output logic o_core_power,
  output logic o_core_start,
  output logic o_core_init,
  output logic [3:0] o_core_channel,
  output logic [1:0] o_core_ref_sel,
  output logic o_temp_sensor_en,
  output logic o_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic [7:0] ctrl;
  logic [7:0] mux_reg;
  logic [2:0] trigger_source_sel;
  logic [9:0] result;
  logic [9:0] result_shown;
  logic lock_result;
  logic result_frozen;
  logic busy;
  logic first_pending;
  logic free_running;
  logic [3:0] active_channel;
  logic [1:0] active_ref;
  logic [4:0] tick_count;
  logic [4:0] conv_len;
  logic tick;
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic trig_prev;
  logic conv_done;
  logic start_req;
  acs_state_type state;
  logic access;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [15:0] shaped;

  assign access = psel && penable;
  assign wr = access && pwrite && pstrb[0];
  assign rd = access && !pwrite;
  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  // Unmapped addresses answer with an error, reads give zero
  assign pslverr = access && !(idx == `ACS_IDX_CTRL || idx == `ACS_IDX_MUX ||
    idx == `ACS_IDX_CTRL_B || idx == `ACS_IDX_RES_LO || idx == `ACS_IDX_RES_HI);

  ////////////////////////////////////////////////////////////////////////////
  // Selection register
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      mux_reg <= `ACS_MUX_RESET;
    else if (wr && idx == `ACS_IDX_MUX)
      mux_reg <= wbyte & `ACS_MUX_WMASK;
  end

  // Trigger source register
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      trigger_source_sel <= 3'h0;
    else if (wr && idx == `ACS_IDX_CTRL_B)
      trigger_source_sel <= wbyte[2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, ticking only while enabled
  acs_prescaler u_prescaler
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_run(ctrl[`ACS_BIT_ENABLE]),
    .i_div_sel(ctrl[2:0]),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trigger input: three stages, edge counted when stages two and three agree
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      trig_prev <= 1'b0;
    end
    else
    begin
      trig_s1 <= i_trigger_sources[trigger_source_sel];
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      if (trig_s2 == trig_s3)
        trig_prev <= trig_s3;
    end
  end

  // Source zero is free running, so its edges never trigger
  logic trig_rise;
  assign trig_rise = (trig_s2 == trig_s3) && trig_s3 && !trig_prev &&
    (trigger_source_sel != 3'h0);
  assign free_running = ctrl[`ACS_BIT_AUTO] && (trigger_source_sel == 3'h0);

  // Start from software or auto trigger; free-running restart is handled in the sequencer
  logic sw_start;
  assign sw_start = wr && idx == `ACS_IDX_CTRL && wbyte[`ACS_BIT_START] &&
    wbyte[`ACS_BIT_ENABLE];
  assign start_req = sw_start ||
    (ctrl[`ACS_BIT_AUTO] && ctrl[`ACS_BIT_ENABLE] && trig_rise);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: counts ticks, latches selections at start
  logic en_write_off;
  logic en_next;
  assign en_write_off = wr && idx == `ACS_IDX_CTRL && !wbyte[`ACS_BIT_ENABLE];
  // Enable as it stands after this edge, so a start written together with
  // the enable bit is not lost while the old enable still reads zero
  assign en_next = (wr && idx == `ACS_IDX_CTRL) ? wbyte[`ACS_BIT_ENABLE] :
    ctrl[`ACS_BIT_ENABLE];
  assign conv_done = (state == ACS_RUN) && tick && (tick_count == conv_len - 5'h01) &&
    !en_write_off;

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state <= ACS_IDLE;
      tick_count <= 5'h00;
      conv_len <= `ACS_CYC_NORMAL;
      active_channel <= 4'h0;
      active_ref <= 2'h0;
    end
    else if (!en_next)
      state <= ACS_IDLE;
    else
    begin
      case (state)
        ACS_IDLE:
        begin
          if (start_req)
          begin
            state <= ACS_RUN;
            tick_count <= 5'h00;
            conv_len <= first_pending ? `ACS_CYC_FIRST : `ACS_CYC_NORMAL;
            active_channel <= mux_reg[3:0];
            active_ref <= mux_reg[7:6];
          end
        end
        ACS_RUN:
        begin
          if (conv_done)
          begin
            // Free running restarts at once, taking the new selection
            state <= free_running ? ACS_RUN : ACS_IDLE;
            tick_count <= 5'h00;
            conv_len <= `ACS_CYC_NORMAL;
            active_channel <= mux_reg[3:0];
            active_ref <= mux_reg[7:6];
          end
          else if (tick)
            tick_count <= tick_count + 5'h01;
        end
        default:
          state <= ACS_IDLE;
      endcase
    end
  end
  assign busy = (state == ACS_RUN);

  // First conversion after enabling needs initialisation
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      first_pending <= 1'b1;
    else if (!ctrl[`ACS_BIT_ENABLE] || en_write_off)
      first_pending <= 1'b1;
    else if (busy)
      first_pending <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status register; flag set wins over a clear
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      ctrl <= `ACS_CTRL_RESET;
    else
    begin
      if (wr && idx == `ACS_IDX_CTRL)
      begin
        ctrl[7] <= wbyte[7];
        ctrl[5] <= wbyte[5];
        ctrl[3:0] <= wbyte[3:0];
      end
      // Start bit mirrors busy; written zero has no effect
      if (!en_next)
        ctrl[`ACS_BIT_START] <= 1'b0;
      else
        ctrl[`ACS_BIT_START] <= busy ? !conv_done || free_running : start_req;
      if (conv_done && !result_frozen)
        ctrl[`ACS_BIT_FLAG] <= 1'b1;
      else if ((wr && idx == `ACS_IDX_CTRL && wbyte[`ACS_BIT_FLAG]) || i_irq_vector_ack)
        ctrl[`ACS_BIT_FLAG] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result register with low-then-high read lock
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      result <= 10'h000;
    else if (conv_done && !result_frozen)
      result <= i_core_result;
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      lock_result <= 1'b0;
    else if (rd && idx == `ACS_IDX_RES_LO)
      lock_result <= 1'b1;
    else if (rd && idx == `ACS_IDX_RES_HI)
      lock_result <= 1'b0;
  end

  // Frozen from the low byte's setup phase on, so a pair never mixes results
  assign result_frozen = lock_result ||
    (psel && !pwrite && idx == `ACS_IDX_RES_LO);

  // Adjustment applied at read time so it takes effect immediately
  assign result_shown = result;
  assign shaped = mux_reg[`ACS_BIT_LEFT_ADJ] ? {result_shown, 6'h00} :
    {6'h00, result_shown};

  // Read data, registered in setup phase
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr[9:2])
        `ACS_IDX_CTRL: prdata <= {24'h000000, ctrl};
        `ACS_IDX_MUX: prdata <= {24'h000000, mux_reg};
        `ACS_IDX_CTRL_B: prdata <= {29'h0, trigger_source_sel};
        `ACS_IDX_RES_LO: prdata <= {24'h000000, shaped[7:0]};
        `ACS_IDX_RES_HI: prdata <= {24'h000000, shaped[15:8]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog core side
  assign o_core_power = ctrl[`ACS_BIT_ENABLE];
  // One pulse per conversion, free-running restarts included
  assign o_core_start = (start_req && (state == ACS_IDLE) && en_next) ||
    (conv_done && free_running);
  assign o_core_init = busy && (conv_len == `ACS_CYC_FIRST);
  assign o_core_channel = active_channel;
  assign o_core_ref_sel = active_ref;
  assign o_temp_sensor_en = busy && (active_channel == `ACS_CHAN_TEMP);
  // Interrupt request gated by global enable
  assign o_irq = ctrl[`ACS_BIT_FLAG] && ctrl[`ACS_BIT_IRQ_EN] && i_global_irq_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic unused_done;
  assign unused_done = i_core_done;

  irq_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_irq == (ctrl[4] && ctrl[3] && i_global_irq_en)) else $error("irq gate wrong");
  mux_bit4_a: assert property (@(posedge i_clk) disable iff (i_reset)
    mux_reg[4] == 1'b0) else $error("select bit 4 set");
  flag_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_done && !result_frozen |=> ctrl[4]) else $error("flag not set");
  abort_a: assert property (@(posedge i_clk) disable iff (i_reset)
    en_write_off |=> !busy) else $error("abort failed");
  hold_sel_a: assert property (@(posedge i_clk) disable iff (i_reset)
    busy && !conv_done |=> $stable(active_channel)) else $error("sel moved");
  temp_en_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(busy) && $past(mux_reg[3:0]) == `ACS_CHAN_TEMP |-> o_temp_sensor_en)
    else $error("sensor off");
  len_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(busy) |-> (conv_len == `ACS_CYC_FIRST) == $past(first_pending))
    else $error("len");
  lock_a: assert property (@(posedge i_clk) disable iff (i_reset)
    lock_result |=> $stable(result)) else $error("result moved");

  // Software start from idle: busy and start bit both show at the next edge
  sequence sw_start_idle_s;
    sw_start && state == ACS_IDLE;
  endsequence
  sequence busy_shown_s;
    busy && ctrl[`ACS_BIT_START];
  endsequence
  start_busy_a: assert property (@(posedge i_clk) disable iff (i_reset)
    sw_start_idle_s |=> busy_shown_s) else $error("start not shown");
  flag_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_irq_vector_ack && !(conv_done && !result_frozen) |=> !ctrl[`ACS_BIT_FLAG])
    else $error("flag not cleared");
  trig_start_a: assert property (@(posedge i_clk) disable iff (i_reset)
    trig_rise && ctrl[`ACS_BIT_AUTO] && ctrl[`ACS_BIT_ENABLE] && en_next &&
    state == ACS_IDLE |=> busy) else $error("trigger ignored");
  free_restart_a: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_done && free_running |=> busy && ctrl[`ACS_BIT_START]) else $error("no restart");
endmodule
`default_nettype wire

// *** verification/acs_core_model.sv ***
// Behavioural model of the analog converter core
`timescale 1ns/1ps
`default_nettype none
module acs_core_model
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [3:0] i_channel,
  output logic [9:0] o_result
);
  logic flip;
  // Sample alternates per start, so a stale result register shows up
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      flip <= 1'b0;
    else if (i_start)
      flip <= ~flip;
  end
  // Channel code in the low bits ties the sample to the selected input
  assign o_result = {flip ? 6'h2A : 6'h15, i_channel};
endmodule
`default_nettype wire

// *** verification/adc_control_sequencer_bench.sv ***
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"
module adc_control_sequencer_bench;
  logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr, gie, vack, err;
  logic pwr, start, init, tsen, irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb, chan;
  logic [7:0] trig;
  logic [9:0] res, r1;
  logic [1:0] rsel;
  int n_errors, n_compared, n;
  acs_sequencer dut (.i_clk(i_clk), .i_reset(i_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_trigger_sources(trig), .i_global_irq_en(gie),
    .i_irq_vector_ack(vack), .i_core_done(1'b0), .i_core_result(res), .o_core_power(pwr),
    .o_core_start(start), .o_core_init(init), .o_core_channel(chan),
    .o_core_ref_sel(rsel), .o_temp_sensor_en(tsen), .o_irq(irq));
  acs_core_model model (.i_clk(i_clk), .i_reset(i_reset), .i_start(start),
    .i_channel(chan), .o_result(res));
  ////////////////////////////////////////////////////////////
  // Free-running system clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // One transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge i_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k == 16)
    begin
      $display("BAD pready expected 1 seen %b", pready);
      n_errors++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rr(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask
  // Edges until the interrupt shows, bounded
  task automatic await_irq();
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (irq !== 1'b1 && n < 4000);
  endtask
  task automatic wait_start(input int lim);
    n = 0;
    while (start !== 1'b1 && n < lim)
    begin
      @(posedge i_clk);
      n++;
    end
  endtask
  // Prescaler phase makes the length uncertain by one tick
  task automatic span(input string what, input int t, input int d);
    chk(what, 1, n >= (t - 1) * d && n <= (t + 1) * d + 4);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    rr("control reset", `ACS_IDX_CTRL, 8'h00);
    rr("select reset", `ACS_IDX_MUX, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped error", 1, err);
    wr(`ACS_IDX_MUX, 8'hFF);
    rr("select bit4", `ACS_IDX_MUX, 8'hEF);
    $display("registers done");
  endtask
  task automatic t_temp();
    wr(`ACS_IDX_MUX, 8'hC8);
    wr(`ACS_IDX_CTRL, 8'hC8);
    rr("start busy", `ACS_IDX_CTRL, 8'hC8);
    chk("temp enable", 1, tsen);
    chk("ref select", 3, rsel);
    chk("init level", 1, init);
    chk("channel", 8, chan);
    await_irq();
    n += 3;
    span("first length", 25, 2);
    r1 = res;
    rr("flag set", `ACS_IDX_CTRL, 8'h98);
    rr("right low", `ACS_IDX_RES_LO, r1[7:0]);
    rr("right high", `ACS_IDX_RES_HI, {6'h0, r1[9:8]});
    wr(`ACS_IDX_MUX, 8'hE8);
    rr("left low", `ACS_IDX_RES_LO, {r1[1:0], 6'h0});
    rr("left high", `ACS_IDX_RES_HI, r1[9:2]);
    wr(`ACS_IDX_CTRL, 8'h98);
    @(posedge i_clk);
    chk("flag written", 0, irq);
    $display("temperature done");
  endtask
  task automatic t_div();
    int d;
    for (int c = 0; c < 8; c++)
    begin
      d = (c < 2) ? 2 : (1 << c);
      wr(`ACS_IDX_CTRL, 8'hC8 | 8'(c));
      await_irq();
      span("normal length", 13, d);
      vack <= 1'b1;
      @(posedge i_clk);
      vack <= 1'b0;
      @(posedge i_clk);
      chk("vector clear", 0, irq);
    end
    $display("prescaler done");
  endtask
  task automatic t_hold();
    wr(`ACS_IDX_MUX, 8'hC3);
    wr(`ACS_IDX_CTRL, 8'hCF);
    wait_start(300);
    wr(`ACS_IDX_MUX, 8'hC5);
    chk("held channel", 3, chan);
    chk("normal no init", 0, init);
    wr(`ACS_IDX_CTRL, 8'h8F);
    rr("start kept", `ACS_IDX_CTRL, 8'hCF);
    gie <= 1'b0;
    n = 0;
    do
    begin
      apb(1'b0, `ACS_IDX_CTRL, 8'h00);
      n++;
    end
    while (rd[4] !== 1'b1 && n < 1000);
    chk("masked irq", 0, irq);
    gie <= 1'b1;
    @(posedge i_clk);
    chk("unmasked irq", 1, irq);
    wr(`ACS_IDX_CTRL, 8'h9F);
    $display("hold done");
  endtask
  task automatic t_abort();
    wr(`ACS_IDX_CTRL, 8'hCF);
    wait_start(300);
    @(posedge i_clk);
    chk("new channel", 5, chan);
    wr(`ACS_IDX_CTRL, 8'h0F);
    @(posedge i_clk);
    chk("power off", 0, pwr);
    rr("aborted", `ACS_IDX_CTRL, 8'h0F);
    repeat (1800) @(posedge i_clk);
    chk("no result", 0, irq);
    $display("abort done");
  endtask
  task automatic t_auto();
    int p;
    p = 0;
    wr(`ACS_IDX_CTRL_B, 8'h02);
    wr(`ACS_IDX_CTRL, 8'hA8);
    trig <= 8'h04;
    wait_start(20);
    chk("trigger start", 1, start);
    trig <= 8'h00;
    await_irq();
    // Source zero high, so an ungated switch would show as a rising edge
    trig <= 8'h01;
    wr(`ACS_IDX_CTRL_B, 8'h00);
    wait_start(40);
    chk("no switch trigger", 0, start);
    wr(`ACS_IDX_CTRL, 8'hE8);
    repeat (120)
    begin
      @(posedge i_clk);
      p += int'(start === 1'b1);
    end
    chk("free run", 1, p >= 3);
    wr(`ACS_IDX_CTRL, 8'h00);
    trig <= 8'h00;
    $display("trigger done");
  endtask
  task automatic t_lock();
    wr(`ACS_IDX_MUX, 8'hC1);
    wr(`ACS_IDX_CTRL, 8'hD8);
    await_irq();
    r1 = res;
    wr(`ACS_IDX_CTRL, 8'hD8);
    rr("low first", `ACS_IDX_RES_LO, r1[7:0]);
    // Conversion ends while frozen: no new result, so no flag either
    repeat (40) @(posedge i_clk);
    chk("locked no flag", 0, irq);
    rr("high locked", `ACS_IDX_RES_HI, {6'h0, r1[9:8]});
    $display("lock done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {i_reset, psel, penable, pwrite, gie, vack} = 6'b100010;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    trig = 8'h00;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_temp();
    t_div();
    t_hold();
    t_abort();
    t_auto();
    t_lock();
    complete_run();
  end
  // Hang guard, well past the expected run of some 8k cycles
  initial
  begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
